// ---- src/pls_slice.sv ----
// Purpose: Configurable logic slice: two tables, muxes, ripple unit, registers.
// Assumes: cfg is static while in use; partner slices share ref_clk.
// Notes:   HAS_RAM clear builds the reduced, RAM-less variant.
`timescale 1ns/1ps
module pls_slice
   import pls_pkg::*;
#(
   parameter bit HAS_RAM = 1'b1
)
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   input  wire pls_cfg_s              cfg,
   input  wire logic [PLS_LUT_IN-1:0] lut_in_a,
   input  wire logic [PLS_LUT_IN-1:0] lut_in_b,
   input  wire logic                  multipurpose_in_a,
   input  wire logic                  multipurpose_in_b,
   input  wire logic                  clk_en,
   input  wire logic                  local_set_reset_in,
   input  wire logic                  carry_chain_in,
   input  wire logic                  wide_mux_in,
   output      logic [PLS_WIDTH-1:0]  lut_bypass_out,
   output      logic [PLS_WIDTH-1:0]  slice_register_out,
   output      logic                  five_input_mux_out,
   output      logic                  wide_mux_out,
   output      logic                  carry_chain_out,
   output      pls_carry_s            carry_gp,
   output      pls_cmp_s              cmp_out
);

   pls_state_s               st_q;
   pls_state_s               st_d;
   logic                     ram_mode;
   logic                     ripple_mode;
   logic                     ram_wr;
   logic [PLS_LUT_DEPTH-1:0] tbl0;
   logic [PLS_LUT_DEPTH-1:0] tbl1;
   logic [PLS_LUT_IN-1:0]    addr1;
   logic                     f0;
   logic                     f1;
   logic [PLS_WIDTH-1:0]     opa;
   logic [PLS_WIDTH-1:0]     opb;
   logic [PLS_WIDTH-1:0]     opb_eff;
   logic [PLS_WIDTH:0]       part;
   logic [PLS_WIDTH:0]       sum;

   // The reduced variant never sees RAM mode; it falls back to ROM reads
   assign ram_mode    = HAS_RAM && (cfg.mode == PLS_MODE_RAM);
   assign ripple_mode = (cfg.mode == PLS_MODE_RIPPLE);
   assign ram_wr      = ram_mode && clk_en && lut_in_b[PLS_RAM_WE_BIT];

   // Single port: both bits share the address on lookup group a
   assign tbl0  = ram_mode ? st_q.ram0 : cfg.lut0_init;
   assign tbl1  = ram_mode ? st_q.ram1 : cfg.lut1_init;
   assign addr1 = ram_mode ? lut_in_a : lut_in_b;

   pls_lut4 u_lut0 (
      .table_bits (tbl0),
      .sel        (lut_in_a),
      .out        (f0)
   );

   pls_lut4 u_lut1 (
      .table_bits (tbl1),
      .sel        (addr1),
      .out        (f1)
   );

   // Operand bit 0 comes from group a, bit 1 from group b
   always_comb begin
      opa     = {lut_in_b[0], lut_in_a[0]};
      opb     = {lut_in_b[1], lut_in_a[1]};
      opb_eff = opb;
      case (cfg.op)
         PLS_OP_ADD: begin
            opb_eff = opb;
         end
         PLS_OP_SUB: begin
            opb_eff = ~opb;
         end
         PLS_OP_ADDSUB: begin
            opb_eff = multipurpose_in_a ? opb : ~opb;
         end
         PLS_OP_UPCNT: begin
            opa     = st_q.q;
            opb_eff = PLS_OP_ZERO;
         end
         PLS_OP_DNCNT: begin
            opa     = st_q.q;
            opb_eff = PLS_OP_ONES;
         end
         PLS_OP_MULT: begin
            opb_eff = opb & {PLS_WIDTH{multipurpose_in_b}};
         end
         PLS_OP_CMP: begin
            opb_eff = ~opb;
         end
         default: begin
            opb_eff = opb;
         end
      endcase
   end

   // Borrow is an inverted carry, so a low stage of a subtractor wants carry in high
   assign part = {1'b0, opa} + {1'b0, opb_eff};
   assign sum  = part + {{PLS_WIDTH{1'b0}}, carry_chain_in};

   assign carry_gp.gen     = part[PLS_WIDTH];
   assign carry_gp.prop    = &(opa ^ opb_eff);
   assign carry_chain_out  = carry_gp.gen | (carry_gp.prop & carry_chain_in);

   // Not-equal chains in from the lower slice on multipurpose input b
   assign cmp_out.ge = carry_chain_out;
   assign cmp_out.ne = (opa != opb) | multipurpose_in_b;
   assign cmp_out.le = ~carry_chain_out | ~cmp_out.ne;

   assign lut_bypass_out     = ripple_mode ? sum[PLS_WIDTH-1:0] : {f1, f0};
   assign five_input_mux_out = multipurpose_in_a ? f1 : f0;
   assign wide_mux_out       = multipurpose_in_b ? wide_mux_in : five_input_mux_out;
   assign slice_register_out = st_q.q;

   always_comb begin
      st_d = st_q;
      if (ram_wr) begin
         st_d.ram0[lut_in_a] = multipurpose_in_a;
         st_d.ram1[lut_in_a] = multipurpose_in_b;
      end else if (!ram_mode && HAS_RAM) begin
         // Preload so entering RAM mode starts from the programmed contents
         st_d.ram0 = cfg.lut0_init;
         st_d.ram1 = cfg.lut1_init;
      end
      if (local_set_reset_in) begin
         st_d.q = cfg.lsr_is_set ? PLS_REG_SET : PLS_REG_CLEAR;
      end else if (clk_en) begin
         st_d.q = lut_bypass_out;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         st_q <= PLS_STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   property p_ram_write;
      (ram_wr && !ram_mode) or (ram_wr ##1 (ram_mode && lut_in_a == $past(lut_in_a)))
         |-> lut_bypass_out == {$past(multipurpose_in_b), $past(multipurpose_in_a)};
   endproperty
   a_ram_write: assert property (p_ram_write) else $error("RAM write not read back");

   property p_ram_hold;
      (ram_mode && !ram_wr) ##1 (ram_mode && lut_in_a == $past(lut_in_a))
         |-> lut_bypass_out == $past(lut_bypass_out);
   endproperty
   a_ram_hold: assert property (p_ram_hold) else $error("RAM changed without write");

   property p_no_ram;
      (cfg.mode == PLS_MODE_RAM && !HAS_RAM) |-> lut_bypass_out == {f1, f0}
         && f0 == cfg.lut0_init[lut_in_a] && f1 == cfg.lut1_init[lut_in_b];
   endproperty
   a_no_ram: assert property (p_no_ram) else $error("Reduced slice acts as RAM");

   property p_lut;
      (cfg.mode == PLS_MODE_LOGIC || cfg.mode == PLS_MODE_ROM)
         |-> lut_bypass_out == {cfg.lut1_init[lut_in_b], cfg.lut0_init[lut_in_a]};
   endproperty
   a_lut: assert property (p_lut) else $error("Lookup output wrong");

   property p_mux;
      wide_mux_out == (multipurpose_in_b ? wide_mux_in
         : (multipurpose_in_a ? lut_bypass_out[1] : lut_bypass_out[0]))
         || ripple_mode;
   endproperty
   a_mux: assert property (p_mux) else $error("Wide mux output wrong");

   property p_add;
      (ripple_mode && cfg.op == PLS_OP_ADD)
         |-> {carry_chain_out, lut_bypass_out}
             == {1'b0, lut_in_b[0], lut_in_a[0]} + {1'b0, lut_in_b[1], lut_in_a[1]}
                + {2'h0, carry_chain_in};
   endproperty
   a_add: assert property (p_add) else $error("Adder result wrong");

   property p_gp;
      ripple_mode |-> carry_chain_out == (carry_gp.gen || (carry_gp.prop && carry_chain_in))
         && !(carry_gp.gen && carry_gp.prop);
   endproperty
   a_gp: assert property (p_gp) else $error("Generate/propagate inconsistent");

   property p_cmp;
      (ripple_mode && cfg.op == PLS_OP_CMP && carry_chain_in && !multipurpose_in_b)
         |-> cmp_out.ge == ({lut_in_b[0], lut_in_a[0]} >= {lut_in_b[1], lut_in_a[1]})
             && cmp_out.le == ({lut_in_b[0], lut_in_a[0]} <= {lut_in_b[1], lut_in_a[1]});
   endproperty
   a_cmp: assert property (p_cmp) else $error("Compare flags wrong");

   property p_upcnt;
      (ripple_mode && cfg.op == PLS_OP_UPCNT && carry_chain_in && clk_en
         && !local_set_reset_in) [*2]
         |-> slice_register_out == $past(slice_register_out) + 2'h1;
   endproperty
   a_upcnt: assert property (p_upcnt) else $error("Up counter did not step");

   property p_reg;
      (clk_en && !local_set_reset_in) |=> slice_register_out == $past(lut_bypass_out);
   endproperty
   a_reg: assert property (p_reg) else $error("Register did not load");

   property p_hold;
      (!clk_en && !local_set_reset_in) |=> $stable(slice_register_out);
   endproperty
   a_hold: assert property (p_hold) else $error("Register moved without enable");

   property p_lsr;
      local_set_reset_in |=> slice_register_out
         == ($past(cfg.lsr_is_set) ? PLS_REG_SET : PLS_REG_CLEAR);
   endproperty
   a_lsr: assert property (p_lsr) else $error("Set/reset not applied");

   c_ram_write: cover property (ram_wr ##1 ram_mode);
   c_carry_out: cover property (ripple_mode && carry_chain_out);
   c_wide_sel:  cover property (!ripple_mode && multipurpose_in_b && wide_mux_in);
   c_count:     cover property (ripple_mode && cfg.op == PLS_OP_DNCNT && clk_en [*3]);

endmodule

// ---- src/pls_pkg.sv ----
// Purpose: Shared types and constants for the programmable logic slice.
// Assumes: One system clock; configuration arrives as a static struct.
// Notes:   What the slice keeps, per tag:
// What this block does
// - Full slice: logic, ripple, RAM, ROM modes
// - Reduced slice: no distributed RAM mode
// - Logic mode: two sixteen-entry four-input tables
// - Two tables muxed into five-input function
// - Wide mux cascades slices for larger functions
// - Ripple: add, subtract, dynamic add/subtract
// - Ripple: up/down counters, multiplier building block
// - Ripple: compare ge, ne, le
// - Ripple: produce carry generate and propagate
// - Carry chain input accepted, output driven
// - RAM mode: single-port sixteen by two memory
// - ROM mode: two sixteen by one tables
// - Two registered, two bypass outputs; ce, set/reset
package pls_pkg;

   localparam int PLS_LUT_IN    = 4;
   localparam int PLS_LUT_DEPTH = 16;
   localparam int PLS_WIDTH     = 2;

   // Lookup input b bit that acts as RAM write enable
   localparam int PLS_RAM_WE_BIT = 0;

   localparam logic [PLS_WIDTH-1:0] PLS_REG_CLEAR = 2'h0;
   localparam logic [PLS_WIDTH-1:0] PLS_REG_SET   = 2'h3;
   localparam logic [PLS_WIDTH-1:0] PLS_OP_ZERO   = 2'h0;
   localparam logic [PLS_WIDTH-1:0] PLS_OP_ONES   = 2'h3;

   typedef enum logic [1:0] {
      PLS_MODE_LOGIC,
      PLS_MODE_RIPPLE,
      PLS_MODE_RAM,
      PLS_MODE_ROM
   } pls_mode_e;

   typedef enum logic [2:0] {
      PLS_OP_ADD,
      PLS_OP_SUB,
      PLS_OP_ADDSUB,
      PLS_OP_UPCNT,
      PLS_OP_DNCNT,
      PLS_OP_MULT,
      PLS_OP_CMP
   } pls_arith_e;

   typedef struct packed {
      pls_mode_e                mode;
      pls_arith_e               op;
      logic [PLS_LUT_DEPTH-1:0] lut0_init;
      logic [PLS_LUT_DEPTH-1:0] lut1_init;
      logic                     lsr_is_set;
   } pls_cfg_s;

   typedef struct packed {
      logic ge;
      logic ne;
      logic le;
   } pls_cmp_s;

   typedef struct packed {
      logic gen;
      logic prop;
   } pls_carry_s;

   typedef struct packed {
      logic [PLS_LUT_DEPTH-1:0] ram0;
      logic [PLS_LUT_DEPTH-1:0] ram1;
      logic [PLS_WIDTH-1:0]     q;
   } pls_state_s;

   localparam pls_state_s PLS_STATE_RST = '0;

endpackage

// ---- src/pls_lut4.sv ----
// Purpose: One four-input lookup table read combinationally.
// Assumes: Table contents are supplied by the caller.
// Notes:   Shared by logic, ROM and RAM read paths.
`timescale 1ns/1ps
module pls_lut4
   import pls_pkg::*;
(
   input  wire logic [PLS_LUT_DEPTH-1:0] table_bits,
   input  wire logic [PLS_LUT_IN-1:0]    sel,
   output      logic                     out
);

   assign out = table_bits[sel];

endmodule

// ---- bench/pls_nbr.sv ----
// Purpose: Neighbour slice model feeding the carry chain and wide mux cascade.
// Assumes: Neighbour paths are combinational, like the slice's own.
// Notes:   Bench sets its propagate, carry-in and cascade value.
`timescale 1ns/1ps
module pls_nbr
(
   input  wire logic prop,
   input  wire logic cin,
   input  wire logic mux_val,
   output      logic carry_out,
   output      logic mux_out
);
   // Pure propagate, so the bench picks the carry seen downstream
   assign carry_out = prop & cin;
   assign mux_out   = mux_val;
endmodule

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the configurable logic slice.
// Assumes: Inputs change at the falling edge; combinational outputs sampled 1 ns later, register output at the edge.
// Notes:   Carry-in and cascade input come from the neighbour model.
`timescale 1ns/1ps
module testbench;
   import pls_pkg::*;
   logic       ref_clk = 1'b0;
   logic       rst_b = 1'b0;
   pls_cfg_s   cfg = '0;
   logic [3:0] lut_in_a = 4'h0;
   logic [3:0] lut_in_b = 4'h0;
   logic       m_a = 1'b0;
   logic       m_b = 1'b0;
   logic       clk_en = 1'b0;
   logic       set_rst = 1'b0;
   logic       nb_prop = 1'b1;
   logic       nb_cin = 1'b0;
   logic       nb_mux = 1'b0;
   logic       carry_in;
   logic       casc_in;
   logic [1:0] byp;
   logic [1:0] byp_r;
   logic [1:0] regq;
   logic       fx;
   logic       wx;
   logic       cco;
   pls_carry_s gp;
   pls_cmp_s   cmp;
   int         err_count = 0;
   int         checks = 0;
   pls_arith_e ops [6] = '{PLS_OP_ADD, PLS_OP_SUB, PLS_OP_ADDSUB, PLS_OP_ADDSUB,
                           PLS_OP_MULT, PLS_OP_MULT};

   always #20 ref_clk = ~ref_clk;

   pls_nbr pls_nbr_inst (.prop(nb_prop), .cin(nb_cin), .mux_val(nb_mux),
                         .carry_out(carry_in), .mux_out(casc_in));

   pls_slice #(.HAS_RAM(1'b1)) pls_slice_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg), .lut_in_a(lut_in_a),
      .lut_in_b(lut_in_b), .multipurpose_in_a(m_a), .multipurpose_in_b(m_b),
      .clk_en(clk_en), .local_set_reset_in(set_rst), .carry_chain_in(carry_in),
      .wide_mux_in(casc_in), .lut_bypass_out(byp), .slice_register_out(regq),
      .five_input_mux_out(fx), .wide_mux_out(wx), .carry_chain_out(cco),
      .carry_gp(gp), .cmp_out(cmp));

   // Reduced variant on the same inputs: RAM mode must fall back to the init tables
   pls_slice #(.HAS_RAM(1'b0)) pls_slice_inst_b (
      .ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg), .lut_in_a(lut_in_a),
      .lut_in_b(lut_in_b), .multipurpose_in_a(m_a), .multipurpose_in_b(m_b),
      .clk_en(clk_en), .local_set_reset_in(set_rst), .carry_chain_in(carry_in),
      .wide_mux_in(casc_in), .lut_bypass_out(byp_r), .slice_register_out(),
      .five_input_mux_out(), .wide_mux_out(), .carry_chain_out(),
      .carry_gp(), .cmp_out());

   task automatic chk(string name, logic [3:0] seen, logic [3:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic set_ab(logic [1:0] a, logic [1:0] b, logic cin);
      @(negedge ref_clk);
      nb_cin   = cin;
      lut_in_a = {2'h0, b[0], a[0]};
      lut_in_b = {2'h0, b[1], a[1]};
      #1;
   endtask

   task automatic test_table;
      logic t0, t1;
      cfg.lut0_init = 16'h6996;
      cfg.lut1_init = 16'hf0a5;
      for (int md = 0; md < 2; md++) begin
         cfg.mode = md ? PLS_MODE_ROM : PLS_MODE_LOGIC;
         for (int i = 0; i < 16; i++) begin
            @(negedge ref_clk);
            lut_in_a = 4'(i);
            lut_in_b = 4'(15 - i);
            {nb_mux, m_b, m_a} = 3'(i);
            #1;
            t0 = cfg.lut0_init[i];
            t1 = cfg.lut1_init[15 - i];
            chk("table", byp, {t1, t0});
            chk("five mux", fx, m_a ? t1 : t0);
            chk("wide mux", wx, m_b ? nb_mux : (m_a ? t1 : t0));
         end
      end
      $display("test table done");
   endtask

   task automatic test_arith;
      logic [1:0] a, b, bb;
      logic [2:0] s, g;
      logic       c;
      cfg.mode = PLS_MODE_RIPPLE;
      for (int k = 0; k < 6; k++) begin
         cfg.op = ops[k];
         m_a = (k == 2);
         m_b = (k == 4);
         for (int n = 0; n < 32; n++) begin
            {c, b, a} = 5'(n);
            bb = (k == 1 || k == 3) ? ~b : (k == 5 ? 2'h0 : b);
            s = 3'(a) + 3'(bb) + 3'(c);
            g = 3'(a) + 3'(bb);
            set_ab(a, b, c);
            chk("sum", byp, s[1:0]);
            chk("carry out", cco, s[2]);
            chk("gen prop", gp, {g[2], g == 3'h3});
         end
      end
      cfg.op = PLS_OP_CMP;
      m_b = 1'b0;
      for (int n = 0; n < 16; n++) begin
         {b, a} = 4'(n);
         set_ab(a, b, 1'b1);
         chk("compare", cmp, {a >= b, a != b, a <= b});
      end
      $display("test arith done");
   endtask

   task automatic test_regs;
      cfg.op = PLS_OP_UPCNT;
      cfg.lsr_is_set = 1'b0;
      nb_cin = 1'b1;
      {set_rst, clk_en} = 2'h3;
      @(negedge ref_clk);
      set_rst = 1'b0;
      chk("clear", regq, PLS_REG_CLEAR);
      for (int i = 1; i < 6; i++) begin
         @(negedge ref_clk);
         chk("up count", regq, 4'(i % 4));
      end
      cfg.op = PLS_OP_DNCNT;
      nb_cin = 1'b0;
      @(negedge ref_clk);
      chk("down count", regq, 2'h0);
      clk_en = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("hold", regq, 2'h0);
      // Set must win even with the enable low
      cfg.lsr_is_set = 1'b1;
      set_rst = 1'b1;
      @(negedge ref_clk);
      chk("set", regq, PLS_REG_SET);
      set_rst = 1'b0;
      $display("test regs done");
   endtask

   task automatic ram_op(logic [3:0] adr, logic [1:0] d, logic we, logic en);
      @(negedge ref_clk);
      lut_in_a = adr;
      lut_in_b = {3'h0, we};
      {m_b, m_a} = d;
      clk_en = en;
   endtask

   task automatic test_ram;
      cfg.mode = PLS_MODE_RAM;
      ram_op(4'h5, 2'h1, 1'b1, 1'b1);
      ram_op(4'h6, 2'h2, 1'b1, 1'b1);
      ram_op(4'h5, 2'h3, 1'b1, 1'b0);
      ram_op(4'h6, 2'h1, 1'b0, 1'b1);
      ram_op(4'h5, 2'h0, 1'b0, 1'b0);
      #1 chk("ram 5", byp, 2'h1);
      chk("rom only 5", byp_r, {cfg.lut1_init[lut_in_b], cfg.lut0_init[lut_in_a]});
      ram_op(4'h6, 2'h0, 1'b0, 1'b0);
      #1 chk("ram 6", byp, 2'h2);
      chk("rom only 6", byp_r, {cfg.lut1_init[lut_in_b], cfg.lut0_init[lut_in_a]});
      // Read back in the cycle right after the write edge
      ram_op(4'h9, 2'h3, 1'b1, 1'b1);
      ram_op(4'h9, 2'h0, 1'b0, 1'b0);
      #1 chk("ram 9", byp, 2'h3);
      $display("test ram done");
   endtask

   initial begin
      repeat (8) @(negedge ref_clk);
      rst_b = 1'b1;
      chk("reset q", regq, PLS_REG_CLEAR);
      test_table;
      test_arith;
      test_regs;
      test_ram;
      wrap_up;
   end

   // About ten times the expected run
   initial begin
      #100000;
      err_count++;
      wrap_up;
   end
endmodule
